// File: rtl/mcu_pkg.sv
// constants, field layouts and carrier types for the measurement compute unit
// assumes a 32-bit AHB-Lite register slave and signed 32-bit measurement words
package mcu_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_UPPER = 8'h08;
  localparam logic [7:0] OFF_LOWER = 8'h0C;
  localparam logic [7:0] OFF_CONST_A = 8'h10;
  localparam logic [7:0] OFF_CONST_B = 8'h14;
  localparam logic [7:0] OFF_CONST_C = 8'h18;
  localparam logic [7:0] OFF_NULL = 8'h1C;
  localparam logic [7:0] OFF_RESULT = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_MAX = 8'h28;
  localparam logic [7:0] OFF_MIN = 8'h2C;
  localparam logic [7:0] OFF_SUM_LO = 8'h30;
  localparam logic [7:0] OFF_SUM_HI = 8'h34;
  localparam logic [7:0] OFF_MEAN = 8'h38;

  // ****************************************
  // control and status field positions
  // ****************************************
  localparam int CTRL_LIMIT_BIT = 0;
  localparam int CTRL_SCALE_BIT = 1;
  localparam int CTRL_STAT_BIT = 2;
  localparam int CTRL_NULL_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  localparam int STAT_CLASS_LSB = 0;
  localparam int STAT_ERR_BIT = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [31:0] RST_UPPER = 32'h0000_0000;
  localparam logic [31:0] RST_LOWER = 32'h0000_0000;
  localparam logic [31:0] RST_CONST_A = 32'h0000_0001;
  localparam logic [31:0] RST_CONST_B = 32'h0000_0000;
  localparam logic [31:0] RST_CONST_C = 32'h0000_0001;
  localparam logic [31:0] RST_NULL = 32'h0000_0000;
  localparam logic [31:0] RST_MAX = 32'h8000_0000;
  localparam logic [31:0] RST_MIN = 32'h7FFF_FFFF;

  // comparator outcome
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0,
    CLS_ABOVE = 2'h1,
    CLS_WITHIN = 2'h2,
    CLS_BELOW = 2'h3
  } limit_class_t;

  // header carried with every outgoing record
  typedef struct packed {
    limit_class_t limitClass;
    logic scaled;
    logic scaleError;
  } record_header_t;

  // one outgoing record
  typedef struct packed {
    record_header_t header;
    logic [31:0] value;
  } result_record_t;

endpackage

// File: rtl/measurement_compute_unit.sv
// measurement compute unit: scaling, limit check and running statistics
// assumes one measurement word per measValid pulse, synchronous to ref_clk,
// and an AHB-Lite master that issues single whole-word transfers
`timescale 1ns/1ps

module measurement_compute_unit
  import mcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic measValid,
  input wire logic [31:0] measData,
  output logic resultValid,
  output result_record_t resultRecord,
  output logic aboveLimit,
  output logic withinLimits,
  output logic belowLimit,
  output logic indicatorA,
  output logic maxIndicator,
  output logic minIndicator,
  output logic meanIndicator,
  output logic sumIndicator,
  output logic [7:0] statusByte
);

  // ****************************************
  // classification helper
  // ****************************************
  // used only for the registered class, taken from procVal on each sample while the limit check is on
  function automatic limit_class_t classify(input logic signed [31:0] v,
                                            input logic signed [31:0] hi,
                                            input logic signed [31:0] lo);
    limit_class_t c;
    if (v > hi)
      c = CLS_ABOVE;
    else if (v < lo)
      c = CLS_BELOW;
    else
      c = CLS_WITHIN;
    return c;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [31:0] upper_r;
  logic [31:0] lower_r;
  logic [31:0] constA_r;
  logic [31:0] constB_r;
  logic [31:0] constC_r;
  logic [31:0] null_r;
  logic scaleErr_r;
  logic statEnD_r;
  logic [31:0] count_r;
  logic [31:0] max_r;
  logic [31:0] min_r;
  logic [47:0] sum_r;
  limit_class_t class_r;
  logic [31:0] result_r;
  logic resultErr_r;
  logic resultValid_r;
  logic [31:0] hrdata_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic limitEn;
  logic scaleEn;
  logic statEn;
  logic nullEn;
  logic statRise;
  logic addrTake;
  logic wrDo;
  logic aZero;
  logic signed [31:0] diff;
  logic signed [31:0] quot;
  logic signed [63:0] prod;
  logic [31:0] procVal;
  logic signed [47:0] cntWide;
  logic signed [47:0] meanWide;
  logic [31:0] readMux;

  assign limitEn = ctrl_r[CTRL_LIMIT_BIT];
  assign scaleEn = ctrl_r[CTRL_SCALE_BIT];
  assign statEn = ctrl_r[CTRL_STAT_BIT];
  assign nullEn = ctrl_r[CTRL_NULL_BIT];

  // ****************************************
  // bus slave: address and data phases
  // ****************************************
  // zero wait state, always OKAY; only htrans NONSEQ/SEQ start a transfer
  assign addrTake = hsel && htrans[1] && hready;
  assign wrDo = wrPend_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // write address is held into the data phase where hwdata is valid
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end
    else
    begin
      wrPend_r <= addrTake && hwrite;
      if (addrTake)
        wrAddr_r <= haddr[7:0];
    end
  end

  // read data is captured at the address phase so it stands in the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      hrdata_r <= 32'h0000_0000;
    else if (addrTake && !hwrite)
      hrdata_r <= readMux;
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb
  begin
    readMux = 32'h0000_0000; // unmapped reads return zero
    if (haddr[31:8] == 24'h00_0000)
    begin
      case (haddr[7:0])
        OFF_CTRL: readMux = {28'h000_0000, ctrl_r};
        OFF_STATUS: readMux = {24'h00_0000, statusByte};
        OFF_UPPER: readMux = upper_r;
        OFF_LOWER: readMux = lower_r;
        OFF_CONST_A: readMux = constA_r;
        OFF_CONST_B: readMux = constB_r;
        OFF_CONST_C: readMux = constC_r;
        OFF_NULL: readMux = nullEn ? null_r : 32'h0000_0000;
        OFF_RESULT: readMux = result_r;
        OFF_COUNT: readMux = count_r;
        OFF_MAX: readMux = max_r;
        OFF_MIN: readMux = min_r;
        OFF_SUM_LO: readMux = sum_r[31:0];
        OFF_SUM_HI: readMux = {{16{sum_r[47]}}, sum_r[47:32]};
        OFF_MEAN: readMux = meanWide[31:0];
        default: readMux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // settings store
  // ****************************************
  // enables and constants; a write to an unmapped low-byte offset is dropped, haddr[31:8] is not decoded for writes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= RST_CTRL;
      upper_r <= RST_UPPER;
      lower_r <= RST_LOWER;
      constA_r <= RST_CONST_A;
      constB_r <= RST_CONST_B;
      constC_r <= RST_CONST_C;
    end
    else if (wrDo)
    begin
      case (wrAddr_r)
        OFF_CTRL: ctrl_r <= hwdata[CTRL_WIDTH-1:0];
        OFF_UPPER: upper_r <= hwdata;
        OFF_LOWER: lower_r <= hwdata;
        OFF_CONST_A: constA_r <= hwdata;
        OFF_CONST_B: constB_r <= hwdata;
        OFF_CONST_C: constC_r <= hwdata;
        default: ;
      endcase
    end
  end

  // null constant only accepts edits while the null function is on
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      null_r <= RST_NULL;
    else if (wrDo && wrAddr_r == OFF_NULL && nullEn)
      null_r <= hwdata;
  end

  // ****************************************
  // scaling datapath
  // ****************************************
  // divide then multiply as the formula reads; a zero divisor is swapped
  // for one so no divide by zero is ever built, and the result is flagged
  assign aZero = (constA_r == 32'h0000_0000);
  assign diff = $signed(measData) - $signed(constB_r);
  assign quot = diff / (aZero ? 32'sh0000_0001 : $signed(constA_r));
  assign prod = quot * $signed(constC_r);

  always_comb
  begin
    if (scaleEn && !aZero)
      procVal = prod[31:0];
    else if (scaleEn)
      procVal = measData;
    else
      procVal = measData;
  end

  // sticky error, cleared by writing one to its status bit; a new error wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      scaleErr_r <= 1'b0;
    else if (measValid && scaleEn && aZero)
      scaleErr_r <= 1'b1;
    else if (wrDo && wrAddr_r == OFF_STATUS && hwdata[STAT_ERR_BIT])
      scaleErr_r <= 1'b0;
  end

  // ****************************************
  // result record and limit class
  // ****************************************
  // the comparison sees the scaled value when scaling is on and constA_r is not zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      result_r <= 32'h0000_0000;
      resultErr_r <= 1'b0;
      class_r <= CLS_NONE;
    end
    else if (measValid)
    begin
      result_r <= procVal;
      resultErr_r <= scaleEn && aZero;
      if (limitEn)
        class_r <= classify(procVal, upper_r, lower_r);
      else
        class_r <= CLS_NONE;
    end
  end

  // one-cycle strobe marking a fresh record
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      resultValid_r <= 1'b0;
    else
      resultValid_r <= measValid;
  end

  assign resultValid = resultValid_r;
  assign resultRecord.value = result_r;
  assign resultRecord.header.limitClass = class_r;
  assign resultRecord.header.scaled = scaleEn;
  assign resultRecord.header.scaleError = resultErr_r;

  // ****************************************
  // running statistics
  // ****************************************
  // the enable is delayed once to spot its rising edge
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      statEnD_r <= 1'b0;
    else
      statEnD_r <= statEn;
  end

  assign statRise = statEn && !statEnD_r;

  // a sample landing on the rise cycle starts the fresh accumulation
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      count_r <= 32'h0000_0000;
      max_r <= RST_MAX;
      min_r <= RST_MIN;
      sum_r <= 48'h0000_0000_0000;
    end
    else if (statEn && measValid)
    begin
      if (statRise)
      begin
        count_r <= 32'h0000_0001;
        max_r <= procVal;
        min_r <= procVal;
        sum_r <= {{16{procVal[31]}}, procVal};
      end
      else
      begin
        count_r <= count_r + 32'h0000_0001;
        if ($signed(procVal) > $signed(max_r))
          max_r <= procVal;
        if ($signed(procVal) < $signed(min_r))
          min_r <= procVal;
        sum_r <= sum_r + {{16{procVal[31]}}, procVal};
      end
    end
    else if (statRise)
    begin
      count_r <= 32'h0000_0000;
      max_r <= RST_MAX;
      min_r <= RST_MIN;
      sum_r <= 48'h0000_0000_0000;
    end
  end
  // with the enable low nothing above changes, so values freeze

  // mean is formed on read; an empty count reads as zero
  assign cntWide = $signed({16'h0000, count_r});
  assign meanWide = (count_r == 32'h0000_0000) ? 48'sh0000_0000_0000
                                               : $signed(sum_r) / cntWide;

  // ****************************************
  // indicators and status byte
  // ****************************************
  // indicators are registered so they never glitch on the panel
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aboveLimit <= 1'b0;
      withinLimits <= 1'b0;
      belowLimit <= 1'b0;
      indicatorA <= 1'b0;
      maxIndicator <= 1'b0;
      minIndicator <= 1'b0;
      meanIndicator <= 1'b0;
      sumIndicator <= 1'b0;
    end
    else
    begin
      aboveLimit <= (class_r == CLS_ABOVE);
      withinLimits <= (class_r == CLS_WITHIN);
      belowLimit <= (class_r == CLS_BELOW);
      indicatorA <= scaleEn;
      maxIndicator <= statEn;
      minIndicator <= statEn;
      meanIndicator <= statEn;
      sumIndicator <= statEn;
    end
  end

  // status byte: class, error and the limit, scale and statistics enables
  assign statusByte = {2'b00, statEn, scaleEn, limitEn, scaleErr_r, class_r};

endmodule

// File: testbench/measurement_compute_unit_properties.sv
// checker for the compute unit's result, class and indicator ports
// assumes binding onto measurement_compute_unit; one clock, sync reset
`timescale 1ns/1ps

module measurement_compute_unit_properties
  import mcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic measValid,
  input wire logic [31:0] measData,
  input wire logic resultValid,
  input wire result_record_t resultRecord,
  input wire logic aboveLimit,
  input wire logic withinLimits,
  input wire logic belowLimit,
  input wire logic indicatorA,
  input wire logic maxIndicator,
  input wire logic minIndicator,
  input wire logic meanIndicator,
  input wire logic sumIndicator,
  input wire logic [7:0] statusByte
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a sample taken and its record published
  sequence take_s;
    measValid ##1 resultValid;
  endsequence

  result_pulse_a: assert property (measValid |=> resultValid)
    else $error("no result pulse after a sample");
  class_lamps_a: assert property (take_s |=>
    aboveLimit == ($past(resultRecord.header.limitClass) == CLS_ABOVE) &&
    withinLimits == ($past(resultRecord.header.limitClass) == CLS_WITHIN) &&
    belowLimit == ($past(resultRecord.header.limitClass) == CLS_BELOW))
    else $error("class lamps disagree with record");
  lamp_onehot_a: assert property ($onehot0({aboveLimit, withinLimits, belowLimit}))
    else $error("more than one class lamp lit");
  status_class_a: assert property (statusByte[1:0] == resultRecord.header.limitClass)
    else $error("status class differs from record");
  indicator_a_lamp_a: assert property (indicatorA == $past(statusByte[4]))
    else $error("indicator_a lamp does not follow scale enable");
  stat_lamps_a: assert property ({maxIndicator, minIndicator, meanIndicator,
    sumIndicator} == {4{$past(statusByte[5])}})
    else $error("statistics lamps do not follow enable");
  limit_off_a: assert property (measValid && !statusByte[3] |=>
    resultRecord.header.limitClass == CLS_NONE)
    else $error("class given with limit check off");
  pass_through_a: assert property (measValid && !statusByte[4] |=>
    resultRecord.value == $past(measData) && !resultRecord.header.scaleError)
    else $error("unscaled result altered");
endmodule

// File: testbench/meas_source.sv
// model of the measurement path: one word per pulse, no back-pressure
// assumes the bench calls put and rest only after reset release
`timescale 1ns/1ps

module meas_source
(
  output logic measValid,
  output logic [31:0] measData,
  input wire logic ref_clk
);
  // idle at time zero
  initial
  begin
    measValid = 1'b0;
    measData = 32'h0000_0000;
  end

  // back-to-back calls give back-to-back pulses
  task automatic put(input logic [31:0] d);
    @(posedge ref_clk);
    measValid <= 1'b1;
    measData <= d;
  endtask

  // released word turns to garbage so a stale value never looks valid
  task automatic rest();
    @(posedge ref_clk);
    measValid <= 1'b0;
    measData <= ~measData;
  endtask
endmodule

// File: testbench/measurement_compute_unit_bench.sv
// self-checking bench: bus tasks, reference model and scenarios
// assumes mcu_pkg, meas_source and the property checker compile first
`timescale 1ns/1ps

module measurement_compute_unit_bench;
  import mcu_pkg::*;
  logic ref_clk, rst_n, hsel, hwrite, hready, measValid, resultValid, hreadyout, hresp;
  logic aboveLimit, withinLimits, belowLimit, indicatorA;
  logic maxIndicator, minIndicator, meanIndicator, sumIndicator;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] statusByte;
  logic [31:0] haddr, hwdata, hrdata, measData, rd, seed;
  logic [3:0] ctl;
  result_record_t resultRecord, want;
  result_record_t expq[$];
  int n_fail, cmp_count, cnt, ca, cb, cc, up, lo, mx, mn;
  longint sum;
  int bounds[7] = '{155, -145, 158, -148, 156, -146, -147};
  logic [7:0] rstOff[8] = '{OFF_CTRL, OFF_UPPER, OFF_CONST_A, OFF_CONST_C, OFF_COUNT,
    OFF_MAX, OFF_MIN, 8'h3C};
  logic [31:0] rstVal[8] = '{32'h0000_0000, RST_UPPER, RST_CONST_A, RST_CONST_C,
    32'h0000_0000, RST_MAX, RST_MIN, 32'h0000_0000};

  assign hready = hreadyout;
  measurement_compute_unit measurement_compute_unit_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .measValid(measValid),
    .measData(measData),
    .resultValid(resultValid),
    .resultRecord(resultRecord),
    .aboveLimit(aboveLimit),
    .withinLimits(withinLimits),
    .belowLimit(belowLimit),
    .indicatorA(indicatorA),
    .maxIndicator(maxIndicator),
    .minIndicator(minIndicator),
    .meanIndicator(meanIndicator),
    .sumIndicator(sumIndicator),
    .statusByte(statusByte)
  );
  meas_source meas_source_inst (
    .measValid(measValid),
    .measData(measData),
    .ref_clk(ref_clk)
  );

  // free-running system clock, 50 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one single transfer; no cycle count assumed, only hready is trusted
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1)
      @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1)
      @(posedge ref_clk);
    rd = hrdata;
  endtask

  task automatic clr();
    cnt = 0;
    sum = 0;
    mx = 32'h8000_0000;
    mn = 32'h7FFF_FFFF;
  endtask

  // write and mirror the register into the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == OFF_CTRL && d[2] && !ctl[2])
      clr();
    ctl = (a == OFF_CTRL) ? d[3:0] : ctl;
    up = (a == OFF_UPPER) ? d : up;
    lo = (a == OFF_LOWER) ? d : lo;
    ca = (a == OFF_CONST_A) ? d : ca;
    cb = (a == OFF_CONST_B) ? d : cb;
    cc = (a == OFF_CONST_C) ? d : cc;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("register %h", a), rd, exp);
    chk("bus response", 32'(hresp), 32'h0000_0000);
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {{20{seed[11]}}, seed[11:0]};
  endfunction

  // reference model of one sample, then hand it to the source
  task automatic feed(input logic [31:0] x);
    int v;
    v = x;
    want = '0;
    want.header.scaled = ctl[1];
    if (ctl[1] && ca == 0)
      want.header.scaleError = 1'b1;
    else if (ctl[1])
      v = (v - cb) / ca * cc;
    want.value = v;
    if (ctl[0])
      want.header.limitClass = v > up ? CLS_ABOVE : (v < lo ? CLS_BELOW : CLS_WITHIN);
    if (ctl[2])
    begin
      cnt++;
      sum += v;
      mx = v > mx ? v : mx;
      mn = v < mn ? v : mn;
    end
    expq.push_back(want);
    meas_source_inst.put(x);
  endtask

  task automatic stats_chk();
    rdchk(OFF_COUNT, cnt);
    rdchk(OFF_MAX, mx);
    rdchk(OFF_MIN, mn);
    rdchk(OFF_SUM_LO, sum[31:0]);
    rdchk(OFF_SUM_HI, sum[63:32]);
    rdchk(OFF_MEAN, 32'(cnt != 0 ? sum / cnt : 0));
  endtask

  // every published record against the model, once settled
  always @(negedge ref_clk)
    if (resultValid === 1'b1)
    begin
      chk("record value", resultRecord.value, expq[0].value);
      chk("record header", 32'(resultRecord.header), 32'(expq[0].header));
      void'(expq.pop_front());
    end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 95531;
    {ctl, up, lo, cb} = '0;
    ca = 1;
    cc = 1;
    clr();
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h3C, 32'hFFFF_FFFF);
    foreach (rstOff[i])
      rdchk(rstOff[i], rstVal[i]);
    wr(OFF_NULL, 32'h0000_1234);
    rdchk(OFF_NULL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0008);
    wr(OFF_NULL, 32'h0000_1234);
    rdchk(OFF_NULL, 32'h0000_1234);
    // limits and scaling, with thresholds hit exactly
    wr(OFF_UPPER, 32'h0000_0064);
    wr(OFF_LOWER, 32'hFFFF_FF9C);
    rdchk(OFF_LOWER, 32'hFFFF_FF9C);
    wr(OFF_CONST_A, 32'h0000_0003);
    wr(OFF_CONST_B, 32'h0000_0005);
    rdchk(OFF_CONST_B, 32'h0000_0005);
    wr(OFF_CONST_C, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0003);
    // stored null value must hide again once the null function is off
    rdchk(OFF_NULL, 32'h0000_0000);
    foreach (bounds[i])
      feed(bounds[i]);
    repeat (24) feed(rnd());
    meas_source_inst.rest();
    rdchk(OFF_RESULT, want.value);
    // statistics: fresh start, frozen, restart
    wr(OFF_CTRL, 32'h0000_0005);
    repeat (16) feed(rnd());
    meas_source_inst.rest();
    stats_chk();
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (4) feed(rnd());
    meas_source_inst.rest();
    stats_chk();
    wr(OFF_CTRL, 32'h0000_0004);
    stats_chk();
    repeat (3) feed(rnd());
    meas_source_inst.rest();
    stats_chk();
    // divisor of zero: sticky error, then write-one-to-clear
    wr(OFF_CTRL, 32'h0000_0003);
    wr(OFF_CONST_A, 32'h0000_0000);
    repeat (2) feed(rnd());
    meas_source_inst.rest();
    rdchk(OFF_STATUS, 32'({ctl[2:0], 1'b1, want.header.limitClass}));
    wr(OFF_STATUS, 32'h0000_0004);
    rdchk(OFF_STATUS, 32'({ctl[2:0], 1'b0, want.header.limitClass}));
    chk("queue left", expq.size(), 32'h0000_0000);
    wrap_up();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #2_000_000;
    n_fail++;
    wrap_up();
  end
endmodule

bind measurement_compute_unit measurement_compute_unit_properties
  measurement_compute_unit_properties_inst (.ref_clk, .rst_n, .measValid, .measData,
  .resultValid, .resultRecord, .aboveLimit, .withinLimits, .belowLimit, .indicatorA,
  .maxIndicator, .minIndicator, .meanIndicator, .sumIndicator, .statusByte);
